// ===== rtl/itfd_input_terminal_function_decoder.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "itfd_defs.svh"
// What this block does
// - Code 30 makes the fifth input a pulse frequency input and is honoured on it alone.
// - A code-32 input going valid starts dc braking at once with no ramp down.
// - A valid code-33 normally closed input raises the external fault flag and stops.
// - A valid code-35 input inverts the pid direction given by software.
// - With keypad as command source a code-36 input stops like the keypad stop key.
// - A code-37 input swaps between terminal and communication command sources.
// - A valid code-38 input freezes only the pid integral term.
// - A valid code-39 input replaces frequency source x with the keypad setting.
// - A valid code-40 input replaces frequency source y with the keypad setting.
// - With terminal gain switching chosen, code 43 picks gain set two when valid.
// - A valid code-47 input stops as fast as possible at the current limit.
// - A code-48 input ramps down on deceleration time four in every source mode.
// - Every input is debounced by a filter of 0 to 1000 ms, 10 ms after reset, except the code-30 pulse output path.
module itfd_input_terminal_function_decoder
  import itfd_pkg::*;
#(
  parameter int NUM_INPUTS = 5,
  parameter int TICK_CYCLES = `ITFD_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // terminal pins
  input wire logic [NUM_INPUTS-1:0] multifunction_input,
  // counting and pulse input
  output logic length_clear,
  output logic pulse_input_enable,
  output logic pulse_input,
  // stop and braking actions
  output logic dc_brake_now,
  output logic external_fault_indication,
  output logic keypad_stop_request,
  output logic emergency_stop,
  output logic current_limit_hold,
  output logic decel4_stop,
  output logic [1:0] decel_time_sel,
  output logic drive_stop,
  // command and frequency source
  output itfd_cmd_src_type active_cmd_source,
  output logic freq_x_use_keypad,
  output logic freq_y_use_keypad,
  // pid
  output logic pid_reverse,
  output logic pid_integral_hold,
  output logic pid_gain_set2,
  // interrupt
  output logic irq
);
  localparam int NEV = 6;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // register state
  itfd_cmd_src_type cmd_source, next_cmd_source;
  logic pid_dir, next_pid_dir;
  logic gain_term, next_gain_term;
  logic fault_reset, next_fault_reset;
  logic [5:0] func_code [NUM_INPUTS];
  logic [5:0] next_func_code [NUM_INPUTS];
  logic [9:0] filter_ms, next_filter_ms;
  logic [NEV-1:0] int_status, next_int_status;
  logic [NEV-1:0] int_mask, next_int_mask;
  logic [31:0] next_prdata;
  logic [NEV-1:0] events;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;

  // pin path
  logic [NUM_INPUTS-1:0] sync1, sync2, filt;
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic tick;

  // decode
  logic [63:0] code_valid;
  logic [63:0] prev_valid;

  // next output values
  logic next_length_clear, next_pulse_input_enable, next_pulse_input;
  logic next_dc_brake_now, next_external_fault_indication, next_keypad_stop_request;
  logic next_emergency_stop, next_decel4_stop, next_pid_reverse;
  logic next_pid_integral_hold, next_pid_gain_set2, next_freq_x, next_freq_y;
  itfd_cmd_src_type next_active_cmd_source;

  // two-flop synchroniser on the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= multifunction_input;
      sync2 <= sync1;
    end
  end

  // millisecond tick divider
  always_comb begin
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick) begin
      next_tick_cnt = '0;
    end
  end
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_filt
    itfd_input_filter #(.CNT_W(10)) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .limit(filter_ms),
      .sample(sync2[g]),
      .level(filt[g])
    );
  end

  // map each debounced input onto the code it carries
  always_comb begin
    code_valid = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      // normally closed contact is valid when open
      if (func_code[i] == `ITFD_FC_EXT_FAULT_NC) begin
        code_valid[func_code[i]] = code_valid[func_code[i]] | ~filt[i];
      // pulse code counts only on the fifth input
      end else if (func_code[i] == `ITFD_FC_PULSE_INPUT) begin
        code_valid[func_code[i]] = code_valid[func_code[i]] | (filt[i] & (i == 4));
      end else if (func_code[i] != `ITFD_FUNC_RST) begin
        code_valid[func_code[i]] = code_valid[func_code[i]] | filt[i];
      end
    end
  end

  always_comb begin
    next_length_clear = code_valid[`ITFD_FC_LENGTH_CLEAR] & ~prev_valid[`ITFD_FC_LENGTH_CLEAR];
    // fifth input bypasses the filter as pulse input
    next_pulse_input_enable = (func_code[4] == `ITFD_FC_PULSE_INPUT);
    next_pulse_input = next_pulse_input_enable & sync2[4];
    next_dc_brake_now = code_valid[`ITFD_FC_DC_BRAKE];
    // sticky fault, set wins over reset
    next_external_fault_indication = code_valid[`ITFD_FC_EXT_FAULT_NC] |
                                     (external_fault_indication & ~fault_reset);
    next_pid_reverse = pid_dir ^ code_valid[`ITFD_FC_PID_REVERSE];
    next_keypad_stop_request = code_valid[`ITFD_FC_KEYPAD_STOP] &
                               ~prev_valid[`ITFD_FC_KEYPAD_STOP] &
                               (cmd_source == ITFD_SRC_KEYPAD);
    next_active_cmd_source = cmd_source;
    if (code_valid[`ITFD_FC_CMD_SWITCH]) begin
      case (cmd_source)
        ITFD_SRC_TERMINAL: next_active_cmd_source = ITFD_SRC_COMM;
        ITFD_SRC_COMM: next_active_cmd_source = ITFD_SRC_TERMINAL;
        default: next_active_cmd_source = cmd_source;
      endcase
    end
    next_pid_integral_hold = code_valid[`ITFD_FC_INTEGRAL_HOLD];
    next_freq_x = code_valid[`ITFD_FC_FREQ_X_KEYPAD];
    next_freq_y = code_valid[`ITFD_FC_FREQ_Y_KEYPAD];
    // gain set two when terminal chosen
    next_pid_gain_set2 = gain_term & code_valid[`ITFD_FC_PID_GAIN_SWITCH];
    next_emergency_stop = code_valid[`ITFD_FC_EMERGENCY_STOP];
    // ramp stop on time four in any mode
    next_decel4_stop = code_valid[`ITFD_FC_DECEL4_STOP];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_valid <= '0;
      length_clear <= 1'b0;
      pulse_input_enable <= 1'b0;
      pulse_input <= 1'b0;
      dc_brake_now <= 1'b0;
      external_fault_indication <= 1'b0;
      pid_reverse <= 1'b0;
      keypad_stop_request <= 1'b0;
      active_cmd_source <= ITFD_SRC_KEYPAD;
      pid_integral_hold <= 1'b0;
      freq_x_use_keypad <= 1'b0;
      freq_y_use_keypad <= 1'b0;
      pid_gain_set2 <= 1'b0;
      emergency_stop <= 1'b0;
      decel4_stop <= 1'b0;
    end else begin
      prev_valid <= code_valid;
      length_clear <= next_length_clear;
      pulse_input_enable <= next_pulse_input_enable;
      pulse_input <= next_pulse_input;
      dc_brake_now <= next_dc_brake_now;
      external_fault_indication <= next_external_fault_indication;
      pid_reverse <= next_pid_reverse;
      keypad_stop_request <= next_keypad_stop_request;
      active_cmd_source <= next_active_cmd_source;
      pid_integral_hold <= next_pid_integral_hold;
      freq_x_use_keypad <= next_freq_x;
      freq_y_use_keypad <= next_freq_y;
      pid_gain_set2 <= next_pid_gain_set2;
      emergency_stop <= next_emergency_stop;
      decel4_stop <= next_decel4_stop;
    end
  end

  // derived stop outputs
  assign current_limit_hold = emergency_stop;
  assign decel_time_sel = decel4_stop ? `ITFD_DECEL4_INDEX : 2'h0;
  assign drive_stop = external_fault_indication | emergency_stop | decel4_stop |
                      keypad_stop_request;

  // interrupt events, one cycle each
  always_comb begin
    events = '0;
    events[`ITFD_EV_LENGTH_CLEAR] = next_length_clear;
    events[`ITFD_EV_DC_BRAKE] = next_dc_brake_now & ~dc_brake_now;
    events[`ITFD_EV_EXT_FAULT] = next_external_fault_indication & ~external_fault_indication;
    events[`ITFD_EV_KEYPAD_STOP] = next_keypad_stop_request;
    events[`ITFD_EV_EMERGENCY] = next_emergency_stop & ~emergency_stop;
    events[`ITFD_EV_DECEL4] = next_decel4_stop & ~decel4_stop;
  end
  assign irq = |(int_status & int_mask);

  // apb decode, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `ITFD_ADDR_ACTION);
  assign pslverr = psel & penable & ~addr_ok;

  // register writes and read data
  always_comb begin
    next_cmd_source = cmd_source;
    next_pid_dir = pid_dir;
    next_gain_term = gain_term;
    next_fault_reset = 1'b0;
    next_func_code = func_code;
    next_filter_ms = filter_ms;
    next_int_mask = int_mask;
    next_int_status = int_status;
    next_prdata = prdata;
    if (wr_en && addr_ok) begin
      if (paddr == `ITFD_ADDR_CTRL) begin
        if (pwdata[`ITFD_CTRL_SRC_LSB +: 2] != 2'h3) begin
          next_cmd_source = itfd_cmd_src_type'(pwdata[`ITFD_CTRL_SRC_LSB +: 2]);
        end
        next_pid_dir = pwdata[`ITFD_CTRL_PID_DIR_BIT];
        next_gain_term = pwdata[`ITFD_CTRL_GAIN_TERM_BIT];
        next_fault_reset = pwdata[`ITFD_CTRL_FAULT_RESET_BIT];
      end
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (paddr == `ITFD_ADDR_FUNC_BASE + 12'(4 * i)) begin
          next_func_code[i] = pwdata[5:0];
        end
      end
      // filter time clipped to its range
      if (paddr == `ITFD_ADDR_FILTER) begin
        next_filter_ms = (pwdata > 32'(`ITFD_FILTER_MAX)) ? `ITFD_FILTER_MAX : pwdata[9:0];
      end
      if (paddr == `ITFD_ADDR_INT_STATUS) begin
        next_int_status = int_status & ~pwdata[NEV-1:0];
      end
      if (paddr == `ITFD_ADDR_INT_MASK) begin
        next_int_mask = pwdata[NEV-1:0];
      end
    end
    // new events win over a clear
    next_int_status = next_int_status | events;
    if (rd_setup) begin
      next_prdata = '0;
      if (paddr == `ITFD_ADDR_CTRL) begin
        next_prdata[`ITFD_CTRL_SRC_LSB +: 2] = cmd_source;
        next_prdata[`ITFD_CTRL_PID_DIR_BIT] = pid_dir;
        next_prdata[`ITFD_CTRL_GAIN_TERM_BIT] = gain_term;
      end
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (paddr == `ITFD_ADDR_FUNC_BASE + 12'(4 * i)) begin
          next_prdata[5:0] = func_code[i];
        end
      end
      if (paddr == `ITFD_ADDR_FILTER) next_prdata[9:0] = filter_ms;
      if (paddr == `ITFD_ADDR_STATE) next_prdata[NUM_INPUTS-1:0] = filt;
      if (paddr == `ITFD_ADDR_INT_STATUS) next_prdata[NEV-1:0] = int_status;
      if (paddr == `ITFD_ADDR_INT_MASK) next_prdata[NEV-1:0] = int_mask;
      if (paddr == `ITFD_ADDR_ACTION) begin
        next_prdata[15:0] = {active_cmd_source, decel_time_sel, pid_gain_set2,
                             pid_integral_hold, pid_reverse, freq_y_use_keypad,
                             freq_x_use_keypad, drive_stop, decel4_stop,
                             emergency_stop, keypad_stop_request,
                             external_fault_indication, dc_brake_now,
                             pulse_input_enable};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_source <= ITFD_SRC_KEYPAD;
      pid_dir <= 1'b0;
      gain_term <= 1'b0;
      fault_reset <= 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++) func_code[i] <= `ITFD_FUNC_RST;
      filter_ms <= `ITFD_FILTER_RST;
      int_status <= '0;
      int_mask <= '0;
      prdata <= '0;
    end else begin
      cmd_source <= next_cmd_source;
      pid_dir <= next_pid_dir;
      gain_term <= next_gain_term;
      fault_reset <= next_fault_reset;
      func_code <= next_func_code;
      filter_ms <= next_filter_ms;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      prdata <= next_prdata;
    end
  end

  // named steps used by the checks
  sequence s_keypad_stop_edge;
    $rose(code_valid[`ITFD_FC_KEYPAD_STOP]) && cmd_source == ITFD_SRC_KEYPAD;
  endsequence
  sequence s_one_cycle_pulse(sig);
    sig ##1 !sig;
  endsequence

  a_pulse_fifth_only: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pulse_input_enable == ($past(func_code[4]) == `ITFD_FC_PULSE_INPUT))
    else $error("pulse input enable wrong");
  a_dc_brake_now: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(code_valid[`ITFD_FC_DC_BRAKE]) |=> dc_brake_now && int_status[`ITFD_EV_DC_BRAKE])
    else $error("dc braking late");
  a_ext_fault_stop: assert property (@(posedge pclk) disable iff (!presetn)
    code_valid[`ITFD_FC_EXT_FAULT_NC] |=> external_fault_indication && drive_stop)
    else $error("external fault not raised");
  a_pid_dir_flip: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pid_reverse == ($past(pid_dir) ^ $past(code_valid[`ITFD_FC_PID_REVERSE])))
    else $error("pid direction wrong");
  a_keypad_stop_key: assert property (@(posedge pclk) disable iff (!presetn)
    s_keypad_stop_edge |=> s_one_cycle_pulse(keypad_stop_request))
    else $error("keypad stop pulse wrong");
  a_cmd_src_swap: assert property (@(posedge pclk) disable iff (!presetn)
    (code_valid[`ITFD_FC_CMD_SWITCH] && cmd_source == ITFD_SRC_TERMINAL) |=>
    active_cmd_source == ITFD_SRC_COMM)
    else $error("command source not swapped");
  a_integral_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pid_integral_hold == $past(code_valid[`ITFD_FC_INTEGRAL_HOLD]))
    else $error("integral hold wrong");
  a_freq_x_keypad: assert property (@(posedge pclk) disable iff (!presetn)
    code_valid[`ITFD_FC_FREQ_X_KEYPAD] |=> freq_x_use_keypad)
    else $error("source x not replaced");
  a_freq_y_keypad: assert property (@(posedge pclk) disable iff (!presetn)
    code_valid[`ITFD_FC_FREQ_Y_KEYPAD] |=> freq_y_use_keypad)
    else $error("source y not replaced");
  a_gain_set_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pid_gain_set2 == ($past(gain_term) && $past(code_valid[`ITFD_FC_PID_GAIN_SWITCH])))
    else $error("gain set wrong");
  a_emergency_stop: assert property (@(posedge pclk) disable iff (!presetn)
    code_valid[`ITFD_FC_EMERGENCY_STOP] |=> emergency_stop && current_limit_hold && drive_stop)
    else $error("emergency stop missing");
  a_decel4_any_mode: assert property (@(posedge pclk) disable iff (!presetn)
    code_valid[`ITFD_FC_DECEL4_STOP] |=> decel_time_sel == 2'h3 && drive_stop)
    else $error("decel four stop missing");
  a_length_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(code_valid[`ITFD_FC_LENGTH_CLEAR]) |=> s_one_cycle_pulse(length_clear))
    else $error("length clear pulse wrong");
  a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    |events |=> (int_status & $past(events)) == $past(events))
    else $error("event lost");
endmodule

// ===== include/itfd_defs.svh
`ifndef ITFD_DEFS_SVH
`define ITFD_DEFS_SVH

// apb register offsets
`define ITFD_ADDR_CTRL 12'h000
`define ITFD_ADDR_FUNC_BASE 12'h004
`define ITFD_ADDR_FUNC_LAST 12'h014
`define ITFD_ADDR_FILTER 12'h018
`define ITFD_ADDR_STATE 12'h01c
`define ITFD_ADDR_INT_STATUS 12'h020
`define ITFD_ADDR_INT_MASK 12'h024
`define ITFD_ADDR_ACTION 12'h028

// control register fields
`define ITFD_CTRL_SRC_LSB 0
`define ITFD_CTRL_PID_DIR_BIT 2
`define ITFD_CTRL_GAIN_TERM_BIT 3
`define ITFD_CTRL_FAULT_RESET_BIT 4

// reset values and the filter time limit
`define ITFD_CTRL_SRC_RST 2'h0
`define ITFD_FUNC_RST 6'h00
`define ITFD_FILTER_RST 10'h00a
`define ITFD_FILTER_MAX 10'h3e8

// function codes handled here
`define ITFD_FC_LENGTH_CLEAR 6'h1c
`define ITFD_FC_PULSE_INPUT 6'h1e
`define ITFD_FC_DC_BRAKE 6'h20
`define ITFD_FC_EXT_FAULT_NC 6'h21
`define ITFD_FC_PID_REVERSE 6'h23
`define ITFD_FC_KEYPAD_STOP 6'h24
`define ITFD_FC_CMD_SWITCH 6'h25
`define ITFD_FC_INTEGRAL_HOLD 6'h26
`define ITFD_FC_FREQ_X_KEYPAD 6'h27
`define ITFD_FC_FREQ_Y_KEYPAD 6'h28
`define ITFD_FC_PID_GAIN_SWITCH 6'h2b
`define ITFD_FC_EMERGENCY_STOP 6'h2f
`define ITFD_FC_DECEL4_STOP 6'h30

// interrupt event bit positions
`define ITFD_EV_LENGTH_CLEAR 0
`define ITFD_EV_DC_BRAKE 1
`define ITFD_EV_EXT_FAULT 2
`define ITFD_EV_KEYPAD_STOP 3
`define ITFD_EV_EMERGENCY 4
`define ITFD_EV_DECEL4 5

// timing: filter counts in milliseconds
`define ITFD_CLK_MHZ 10
`define ITFD_TICK_US 1000
`define ITFD_TICK_CYCLES (`ITFD_TICK_US * `ITFD_CLK_MHZ)
`define ITFD_DECEL4_INDEX 2'h3

`endif

// ===== include/itfd_pkg.sv
package itfd_pkg;
  // command source modes
  typedef enum logic [1:0] {
    ITFD_SRC_KEYPAD,
    ITFD_SRC_TERMINAL,
    ITFD_SRC_COMM
  } itfd_cmd_src_type;
endpackage

// ===== rtl/itfd_input_filter.sv
`timescale 1ns/1ps
`include "itfd_defs.svh"
module itfd_input_filter
  import itfd_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timing
  input wire logic tick,
  input wire logic [CNT_W-1:0] limit,
  // terminal
  input wire logic sample,
  output logic level
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_level;

  // level follows sample once it held for limit ticks
  always_comb begin
    next_level = level;
    next_cnt = cnt;
    if (sample == level) begin
      next_cnt = '0;
    end else if (limit == '0) begin
      next_level = sample;
      next_cnt = '0;
    end else if (tick) begin
      if (cnt + 1'b1 >= limit) begin
        next_level = sample;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      cnt <= '0;
    end else begin
      level <= next_level;
      cnt <= next_cnt;
    end
  end

  // level only moves toward the sampled state
  a_filter_toward: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(level) |-> $past(sample) == level)
    else $error("filter moved away from sample");

  // zero filter time passes the input at once
  a_filter_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (limit == '0 && sample != level) |=> level == $past(sample))
    else $error("zero filter did not pass input");
endmodule

// ===== testbench/itfd_contacts.sv
`timescale 1ns/1ps
module itfd_contacts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // contact states asked for by the bench
  input wire logic [4:0] want,
  // levels seen at the terminal pins
  output logic [4:0] pins
);
  // contacts settle one cycle after the command, all open in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 5'h00;
    end else begin
      pins <= want;
    end
  end
endmodule

// ===== testbench/tb_itfd_input_terminal_function_decoder.sv
`timescale 1ns/1ps
`include "itfd_defs.svh"
module tb_itfd_input_terminal_function_decoder
  import itfd_pkg::*;
();
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, length_clear, pulse_input_enable, pulse_input, dc_brake_now;
  logic external_fault_indication, keypad_stop_request, emergency_stop, current_limit_hold;
  logic decel4_stop, drive_stop, freq_x_use_keypad, freq_y_use_keypad, irq;
  logic pid_reverse, pid_integral_hold, pid_gain_set2;
  logic [1:0] decel_time_sel;
  itfd_cmd_src_type active_cmd_source;
  logic [4:0] multifunction_input, want = 5'h00;
  int n_errors = 0, num_checks = 0, cyc = 0;
  logic [31:0] n;
  // function code beside the action word it should give while valid
  logic [37:0] rows [0:18] = '{{6'h1c, 32'h0}, {6'h1d, 32'h0}, {6'h1e, 32'h0},
    {6'h1f, 32'h0}, {6'h20, 32'h2}, {6'h22, 32'h0}, {6'h23, 32'h200}, {6'h24, 32'h0},
    {6'h25, 32'h0}, {6'h26, 32'h400}, {6'h27, 32'h80}, {6'h28, 32'h100}, {6'h29, 32'h0},
    {6'h2a, 32'h0}, {6'h2b, 32'h800}, {6'h2c, 32'h0}, {6'h2d, 32'h0}, {6'h2e, 32'h0},
    {6'h2f, 32'h50}};

  always #50 pclk = ~pclk;

  itfd_input_terminal_function_decoder #(.NUM_INPUTS(5), .TICK_CYCLES(4))
    i_itfd_input_terminal_function_decoder (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .multifunction_input, .length_clear,
    .pulse_input_enable, .pulse_input, .dc_brake_now, .external_fault_indication,
    .keypad_stop_request, .emergency_stop, .current_limit_hold, .decel4_stop,
    .decel_time_sel, .drive_stop, .active_cmd_source, .freq_x_use_keypad,
    .freq_y_use_keypad, .pid_reverse, .pid_integral_hold, .pid_gain_set2, .irq);

  itfd_contacts i_itfd_contacts (.pclk, .presetn, .want, .pins(multifunction_input));

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wt(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // one apb transfer, read data and error taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task drive(input logic [4:0] v, input int c);
    @(posedge pclk);
    want <= v;
    wt(c);
  endtask

  initial begin
    wt(10);
    presetn <= 1'b1;
    apb(0, `ITFD_ADDR_FILTER, 0);
    chk("filter reset", q, 32'ha);
    apb(0, 12'h02c, 0);
    chk("unmapped error", err, 1);
    chk("unmapped data", q, 0);
    apb(1, `ITFD_ADDR_FUNC_BASE, 32'h20);
    drive(5'h01, 20);
    drive(5'h00, 30);
    chk("short glitch", dc_brake_now, 0);
    drive(5'h01, 60);
    chk("filtered brake", dc_brake_now, 1);
    drive(5'h00, 60);
    $display("test filter done");
    apb(1, `ITFD_ADDR_FILTER, 0);
    apb(1, `ITFD_ADDR_CTRL, 32'h8);
    for (int i = 0; i < 19; i++) begin
      apb(1, `ITFD_ADDR_FUNC_BASE, 32'(rows[i][37:32]));
      drive(5'h01, 8);
      apb(0, `ITFD_ADDR_ACTION, 0);
      chk($sformatf("action %h", rows[i][37:32]), q & 32'hfff7, rows[i][31:0]);
      chk("current limit", current_limit_hold, rows[i][4]);
      drive(5'h00, 8);
      apb(0, `ITFD_ADDR_ACTION, 0);
      chk("action idle", q & 32'hfff7, 0);
    end
    apb(1, `ITFD_ADDR_CTRL, 32'hc);
    apb(0, `ITFD_ADDR_ACTION, 0);
    chk("pid dir param", q & 32'hfff7, 32'h200);
    apb(1, `ITFD_ADDR_CTRL, 32'h8);
    $display("test table done");
    apb(1, `ITFD_ADDR_FUNC_BASE + 12'h010, 32'h1e);
    drive(5'h10, 8);
    chk("pulse enable", pulse_input_enable, 1);
    chk("pulse high", pulse_input, 1);
    drive(5'h00, 8);
    chk("pulse low", pulse_input, 0);
    apb(1, `ITFD_ADDR_FUNC_BASE + 12'h010, 0);
    $display("test pulse done");
    apb(1, `ITFD_ADDR_FUNC_BASE, 32'h1c);
    apb(1, `ITFD_ADDR_INT_STATUS, 32'h3f);
    apb(1, `ITFD_ADDR_INT_MASK, 1);
    drive(5'h01, 0);
    n = 0;
    repeat (10) begin
      @(posedge pclk);
      n += length_clear;
    end
    chk("clear pulse", n, 1);
    chk("irq set", irq, 1);
    apb(1, `ITFD_ADDR_INT_MASK, 0);
    wt(1);
    chk("irq masked", irq, 0);
    apb(1, `ITFD_ADDR_INT_STATUS, 1);
    apb(0, `ITFD_ADDR_INT_STATUS, 0);
    chk("status cleared", q, 0);
    drive(5'h00, 8);
    $display("test length done");
    apb(1, `ITFD_ADDR_FUNC_BASE, 32'h21);
    wt(8);
    chk("fault set", external_fault_indication, 1);
    chk("fault stop", drive_stop, 1);
    drive(5'h01, 8);
    chk("fault sticky", external_fault_indication, 1);
    apb(1, `ITFD_ADDR_CTRL, 32'h18);
    wt(2);
    chk("fault reset", external_fault_indication, 0);
    drive(5'h00, 8);
    $display("test fault done");
    apb(1, `ITFD_ADDR_FUNC_BASE, 32'h24);
    for (int s = 0; s < 2; s++) begin
      apb(1, `ITFD_ADDR_CTRL, 32'h8 | s);
      apb(1, `ITFD_ADDR_INT_STATUS, 32'h3f);
      drive(5'h01, 8);
      apb(0, `ITFD_ADDR_INT_STATUS, 0);
      chk("keypad stop", q[3], s == 0);
      drive(5'h00, 8);
    end
    $display("test keypad stop done");
    apb(1, `ITFD_ADDR_FUNC_BASE, 32'h25);
    apb(1, `ITFD_ADDR_FUNC_BASE + 12'h004, 32'h30);
    for (int s = 0; s < 3; s++) begin
      apb(1, `ITFD_ADDR_CTRL, 32'h8 | s);
      drive(5'h03, 8);
      apb(0, `ITFD_ADDR_ACTION, 0);
      chk("source and decel", q[15:12], (s == 0 ? 0 : 3 - s) * 4 + 3);
      chk("decel stop", q[6:5], 2'h3);
      drive(5'h00, 8);
    end
    $display("test source done");
    // reset in mid-run, with the fault latched again since the end of the fault test, checks it clears and restores the filter time
    @(posedge pclk);
    presetn <= 1'b0;
    wt(3);
    chk("reset fault", external_fault_indication, 0);
    chk("reset source", active_cmd_source, 0);
    presetn <= 1'b1;
    apb(0, `ITFD_ADDR_FILTER, 0);
    chk("filter after reset", q, 32'ha);
    $display("test reset done");
    conclude();
  end
endmodule
